/* verilog/dcr_pkg.sv */
// Purpose: Shared constants and carrier types for the debug control register block.
// Assumes: One 8-bit control register reached by host commands over the debug link.
// Notes: Bit positions, reset value and command codes live here only.
package dcr_pkg;
    // =====================================================================
    // Register layout
    localparam logic [7:0] DCR_RESET_VAL = 8'h00;
    localparam int DCR_HALT_BIT = 7;
    localparam int DCR_BREAKPOINT_ENABLE_BIT_BIT = 6;
    localparam int DCR_ACKEN_BIT = 5;
    localparam int DCR_SPIN_BIT = 4;
    localparam int DCR_PCM_BIT = 3;
    localparam int DCR_CZ_BIT = 2;
    localparam int DCR_RSVD_BIT = 1;
    localparam int DCR_RST_BIT = 0;
    // =====================================================================
    // Link commands, codes and counter values
    localparam logic [7:0] DCR_CMD_READ_CTL = 8'h05;
    localparam logic [7:0] DCR_CMD_WRITE_CTL = 8'h04;
    localparam logic [7:0] DCR_ACK_BYTE = 8'hff;
    localparam logic [7:0] DCR_BREAK_OPCODE = 8'h00;
    localparam logic [15:0] DCR_CNT_ZERO = 16'h0000;
    localparam logic [15:0] DCR_CNT_ONE = 16'h0001;

    // Host-side write request from the command decoder.
    typedef struct packed {
        logic wr;
        logic [7:0] data;
    } dcr_host_wr_t;

    // Processor-side events sampled each cycle.
    typedef struct packed {
        logic brk_decoded;
        logic [15:0] pc;
        logic instr_retired;
    } dcr_cpu_evt_t;
endpackage : dcr_pkg

/* verilog/dcr_debug_control.sv */
// Purpose: Debug control register with halt, break, acknowledge and counter breakpoint logic.
// Assumes: Host command decoding of the serial link is done outside; writes arrive as one-cycle strobes.
// Notes: The device reset request is held until the system reports that its reset sequence is done.
`timescale 1ns/1ps
module dcr_debug_control (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire dcr_pkg::dcr_host_wr_t host_wr_i,
    input wire logic host_rd_i,
    input wire dcr_pkg::dcr_cpu_evt_t cpu_evt_i,
    input wire logic sys_reset_done_i,
    input wire logic ack_tx_done_i,
    input wire logic cnt_load_i,
    input wire logic [15:0] cnt_load_val_i,
    output logic [7:0] ctl_o,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic fetch_stop_o,
    output logic brk_spin_o,
    output logic brk_nop_o,
    output logic sys_reset_o,
    output logic ack_tx_req_o,
    output logic [7:0] ack_byte_o,
    output logic cpu_idle_o,
    output logic [15:0] cnt_o
);
    import dcr_pkg::*;

    logic [7:0] ctl_q;
    logic [15:0] cnt_q;
    logic brk_seen_q;
    logic ack_pend_q;
    logic rd_valid_q;
    logic [7:0] rd_data_q;
    logic brk_en;
    logic brk_fire;
    logic pcm_hit;
    logic cz_hit;
    logic auto_halt;
    logic [7:0] ctl_d;
    logic brk_seen_d;
    logic spin_q;
    logic nop_q;
    logic idle_q;

    // =====================================================================
    // Break and breakpoint event decode
    // The opcode value is not compared here; the core flags its decode.
    // break disabled
    assign brk_en = ctl_q[DCR_BREAKPOINT_ENABLE_BIT_BIT];
    assign brk_fire = cpu_evt_i.brk_decoded & brk_en;
    assign pcm_hit = ctl_q[DCR_PCM_BIT] & ~ctl_q[DCR_HALT_BIT] & (cpu_evt_i.pc == cnt_q);
    // zero count break
    // A load in the same cycle overrides the decrement, so it must not trip the break.
    assign cz_hit = ctl_q[DCR_CZ_BIT] & ~ctl_q[DCR_PCM_BIT] & ~ctl_q[DCR_HALT_BIT]
                  & cpu_evt_i.instr_retired & ~cnt_load_i & (cnt_q == DCR_CNT_ONE);
    assign auto_halt = (brk_fire & ~ctl_q[DCR_SPIN_BIT]) | pcm_hit | cz_hit;

    // =====================================================================
    // Control register next value; hardware events are applied after the host write.
    // The status flops below read this value, so they move on the same edge as the register.
    always_comb begin
        ctl_d = ctl_q;
        if (host_wr_i.wr) begin
            ctl_d = host_wr_i.data;
            ctl_d[DCR_RSVD_BIT] = 1'b0;
            ctl_d[DCR_RST_BIT] = host_wr_i.data[DCR_RST_BIT] | (ctl_q[DCR_RST_BIT] & ~sys_reset_done_i);
        end else if (sys_reset_done_i) begin
            ctl_d[DCR_RST_BIT] = 1'b0;
        end
        // Hardware halt wins over a coincident host write.
        if (auto_halt) begin
            ctl_d[DCR_HALT_BIT] = 1'b1;
        end
        if (ack_tx_done_i & ack_pend_q) begin
            ctl_d[DCR_ACKEN_BIT] = 1'b0;
        end
    end

    // Control register; only power-on reset clears it, so a device reset keeps it.
    // bits survive soft reset
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctl_q <= DCR_RESET_VAL;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    // =====================================================================
    // Acknowledge byte request; held until the transmitter reports it sent.
    // acknowledge on break
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_pend_q <= 1'b0;
        end else if ((brk_fire | pcm_hit | cz_hit) & ctl_q[DCR_ACKEN_BIT] & ~ack_pend_q) begin
            ack_pend_q <= 1'b1;
        end else if (ack_tx_done_i) begin
            ack_pend_q <= 1'b0;
        end
    end

    // =====================================================================
    // Debug counter: counts retired instructions down unless in match mode or halted.
    // It is never cleared on leaving debug state, which keeps zero-break counts intact.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= DCR_CNT_ZERO;
        end else if (cnt_load_i) begin
            cnt_q <= cnt_load_val_i;
        end else if (~ctl_q[DCR_PCM_BIT] & ~ctl_q[DCR_HALT_BIT] & cpu_evt_i.instr_retired) begin
            cnt_q <= cnt_q - DCR_CNT_ONE;
        end
    end

    // =====================================================================
    // Break-seen flag for idle status; a break in the same cycle as a write wins.
    always_comb begin
        brk_seen_d = brk_seen_q;
        if (brk_fire) begin
            brk_seen_d = 1'b1;
        end else if (host_wr_i.wr) begin
            brk_seen_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            brk_seen_q <= 1'b0;
        end else begin
            brk_seen_q <= brk_seen_d;
        end
    end

    // =====================================================================
    // Status outputs
    // Registered from next values so that every output leaves a flip-flop without extra lag.
    // status flops
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            spin_q <= DCR_RESET_VAL[DCR_BREAKPOINT_ENABLE_BIT_BIT] & DCR_RESET_VAL[DCR_SPIN_BIT];
            nop_q <= ~DCR_RESET_VAL[DCR_BREAKPOINT_ENABLE_BIT_BIT];
            idle_q <= DCR_RESET_VAL[DCR_HALT_BIT];
        end else begin
            spin_q <= ctl_d[DCR_BREAKPOINT_ENABLE_BIT_BIT] & ctl_d[DCR_SPIN_BIT];
            nop_q <= ~ctl_d[DCR_BREAKPOINT_ENABLE_BIT_BIT];
            idle_q <= ctl_d[DCR_HALT_BIT] | brk_seen_d;
        end
    end

    // =====================================================================
    // Read answer for the read-control command.
    // read back
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_valid_q <= 1'b0;
            rd_data_q <= DCR_RESET_VAL;
        end else begin
            rd_valid_q <= host_rd_i;
            if (host_rd_i) begin
                rd_data_q <= ctl_q;
            end
        end
    end

    // =====================================================================
    // Outputs, all straight from flip-flops except the constant ack_byte_o.
    // device reset request
    assign sys_reset_o = ctl_q[DCR_RST_BIT];
    assign ctl_o = ctl_q;
    assign rd_data_o = rd_data_q;
    assign rd_valid_o = rd_valid_q;
    assign fetch_stop_o = ctl_q[DCR_HALT_BIT];
    assign brk_spin_o = spin_q;
    assign brk_nop_o = nop_q;
    assign ack_tx_req_o = ack_pend_q;
    assign ack_byte_o = DCR_ACK_BYTE;
    assign cpu_idle_o = idle_q;
    assign cnt_o = cnt_q;

    // =====================================================================
    // Assertions
    sequence brk_halt_s;
        cpu_evt_i.brk_decoded && ctl_q[DCR_BREAKPOINT_ENABLE_BIT_BIT] && !ctl_q[DCR_SPIN_BIT];
    endsequence

    break_halts_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        brk_halt_s |=> fetch_stop_o) else $error("Enabled break did not halt.");
    break_nop_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (cpu_evt_i.brk_decoded && !brk_en && !pcm_hit && !cz_hit && !host_wr_i.wr && !fetch_stop_o)
        |=> !fetch_stop_o) else $error("Disabled break changed halt.");
    pc_match_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        pcm_hit |=> fetch_stop_o) else $error("PC match did not halt.");
    count_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (ctl_q[DCR_PCM_BIT] && !cnt_load_i) |=> $stable(cnt_q)) else $error("Counter moved in match mode.");
    zero_break_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        cz_hit |=> (fetch_stop_o && cnt_q == DCR_CNT_ZERO)) else $error("Zero count did not halt.");
    ack_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (ack_pend_q && ack_tx_done_i) |=> !ctl_q[DCR_ACKEN_BIT]) else $error("Ack enable not cleared.");
    reset_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (sys_reset_done_i && !(host_wr_i.wr && host_wr_i.data[DCR_RST_BIT])) |=> !sys_reset_o)
        else $error("Reset bit did not clear.");
    read_back_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        host_rd_i |=> (rd_valid_o && rd_data_o == $past(ctl_q))) else $error("Read answer wrong.");
    idle_report_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (brk_fire ##1 !host_wr_i.wr) |=> cpu_idle_o) else $error("Idle not reported after break.");
    halt_reset_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (host_wr_i.wr && host_wr_i.data == 8'h81) |=> (fetch_stop_o && sys_reset_o))
        else $error("Reset and stop failed.");
endmodule : dcr_debug_control

/* verif/dcr_sys_partner.sv */
// Purpose: Far-side model that completes a request after a set number of cycles.
// Assumes: The request is a level that drops the cycle after the done pulse.
// Notes: Two copies stand in for the reset sequencer and the link transmitter.
`timescale 1ns/1ps
module dcr_sys_partner #(
    parameter int LAT = 3
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic req_i,
    output logic done_o
);
    logic [7:0] cnt_q;
    // =====================================================================
    // Completion
    // late completion pulse
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= 8'h00;
            done_o <= 1'b0;
        end else begin
            done_o <= req_i && (cnt_q == 8'(LAT));
            cnt_q <= (req_i && cnt_q != 8'(LAT)) ? cnt_q + 8'h01 : 8'h00;
        end
    end
endmodule : dcr_sys_partner

/* verif/dcr_debug_control_tb.sv */
// Purpose: Self-checking bench for the debug control register.
// Assumes: Inputs change 5 ns after each rising edge.
// Notes: Table rows first, then hand-written break, reset and counter cases.
`timescale 1ns/1ps
module dcr_debug_control_tb;
    import dcr_pkg::*;
    typedef struct packed {logic [7:0] d; logic [7:0] e;} dcr_row_t;
    logic ref_clk_i = 1'b0, rst_b_i = 1'b0, host_rd_i = 1'b0, cnt_load_i = 1'b0;
    logic sys_reset_done_i, ack_tx_done_i;
    logic [15:0] cnt_load_val_i = 16'h0000;
    dcr_host_wr_t host_wr_i = '0;
    dcr_cpu_evt_t evt = '0;
    logic [7:0] ctl_o, rd_data_o, ack_byte_o;
    logic rd_valid_o, fetch_stop_o, brk_spin_o, brk_nop_o, sys_reset_o, ack_tx_req_o, cpu_idle_o;
    logic [15:0] cnt_o;
    int miscompares = 0, n_checks = 0;
    dcr_row_t rows [4] = '{'{8'h40, 8'h40}, '{8'hfc, 8'hfc}, '{8'h06, 8'h04}, '{8'h00, 8'h00}};
    dcr_debug_control u_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .host_wr_i(host_wr_i),
        .host_rd_i(host_rd_i), .cpu_evt_i(evt), .sys_reset_done_i(sys_reset_done_i),
        .ack_tx_done_i(ack_tx_done_i), .cnt_load_i(cnt_load_i), .cnt_load_val_i(cnt_load_val_i),
        .ctl_o(ctl_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .fetch_stop_o(fetch_stop_o),
        .brk_spin_o(brk_spin_o), .brk_nop_o(brk_nop_o), .sys_reset_o(sys_reset_o),
        .ack_tx_req_o(ack_tx_req_o), .ack_byte_o(ack_byte_o), .cpu_idle_o(cpu_idle_o), .cnt_o(cnt_o));
    // A slow reset sequencer and a prompt transmitter exercise both paces.
    dcr_sys_partner #(.LAT(6)) u_rst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .req_i(sys_reset_o),
        .done_o(sys_reset_done_i));
    dcr_sys_partner #(.LAT(1)) u_ack (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .req_i(ack_tx_req_o),
        .done_o(ack_tx_done_i));
    // =====================================================================
    // Clock, helpers and closing
    initial begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    task tick;
        @(posedge ref_clk_i);
        #5;
    endtask : tick
    task wr(input logic [7:0] d);
        host_wr_i = '{1'b1, d & 8'hfd};
        tick;
        host_wr_i.wr = 1'b0;
    endtask : wr
    task break_opcode;
        evt.brk_decoded = 1'b1;
        tick;
        evt.brk_decoded = 1'b0;
    endtask : break_opcode
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task tally_and_finish;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // The whole sequence needs under a hundred cycles; the margin covers slow partners.
    initial begin
        repeat (3000) @(posedge ref_clk_i);
        miscompares++;
        tally_and_finish;
    end
    // =====================================================================
    // Sequence
    initial begin
        repeat (4) @(posedge ref_clk_i);
        #5 rst_b_i = 1'b1;
        chk({ctl_o, ack_byte_o}, 16'h00ff);
        chk(brk_nop_o, 1'b1);
        foreach (rows[i]) begin
            wr(rows[i].d);
            chk(ctl_o, rows[i].e);
            chk(fetch_stop_o, rows[i].e[7]);
            host_rd_i = 1'b1;
            tick;
            host_rd_i = 1'b0;
            chk({rd_valid_o, rd_data_o}, {1'b1, rows[i].e});
        end
        break_opcode;
        tick;
        chk({fetch_stop_o, cpu_idle_o}, 2'b00);
        wr(8'h81);
        chk({sys_reset_o, fetch_stop_o}, 2'b11);
        tick;
        wr(8'h80);
        chk(sys_reset_o, 1'b1);
        for (int i = 0; i < 20 && sys_reset_o; i++) tick;
        chk(ctl_o, 8'h80);
        wr(8'h40);
        chk({fetch_stop_o, cpu_idle_o}, 2'b00);
        tick;
        wr(8'h41);
        for (int i = 0; i < 20 && sys_reset_o; i++) tick;
        chk({ctl_o, fetch_stop_o}, {8'h40, 1'b0});
        wr(8'h60);
        break_opcode;
        chk({fetch_stop_o, cpu_idle_o, ack_tx_req_o}, 3'b111);
        for (int i = 0; i < 10 && ack_tx_req_o; i++) tick;
        chk(ctl_o, 8'hc0);
        wr(8'h50);
        chk(brk_spin_o, 1'b1);
        break_opcode;
        chk({fetch_stop_o, cpu_idle_o}, 2'b01);
        wr(8'h04);
        cnt_load_val_i = 16'h0002;
        cnt_load_i = 1'b1;
        tick;
        cnt_load_i = 1'b0;
        evt.instr_retired = 1'b1;
        tick;
        tick;
        evt.instr_retired = 1'b0;
        tick;
        chk({cnt_o, fetch_stop_o}, {16'h0000, 1'b1});
        wr(8'h04);
        chk(cnt_o, 16'h0000);
        tick;
        // Keep the program counter off the counter value until the match is wanted.
        evt.pc = 16'h4321;
        wr(8'h08);
        cnt_load_val_i = 16'h1234;
        cnt_load_i = 1'b1;
        tick;
        cnt_load_i = 1'b0;
        evt.instr_retired = 1'b1;
        tick;
        evt.instr_retired = 1'b0;
        chk({cnt_o, fetch_stop_o}, {16'h1234, 1'b0});
        evt.pc = 16'h1234;
        tick;
        tick;
        chk(fetch_stop_o, 1'b1);
        // A power-on reset in mid-run must clear every bit, unlike the device reset.
        rst_b_i = 1'b0;
        tick;
        rst_b_i = 1'b1;
        chk({ctl_o, cnt_o, brk_nop_o, cpu_idle_o}, {8'h00, 16'h0000, 1'b1, 1'b0});
        tally_and_finish;
    end
endmodule : dcr_debug_control_tb
